// ### rtl/cscc_div.sv
/*
 * Rate divider giving a one-cycle enable pulse every DIV sys_clk cycles.
 * Assumes a single clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
module cscc_div #(
	parameter int DIV = 2
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// enable pulse
	output logic      tick
);
	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         tick_nxt;

	always_comb begin
		tick_nxt = (cnt_r == LAST);
		cnt_nxt  = tick_nxt ? '0 : W'(cnt_r + 1'b1);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick  <= tick_nxt;
		end
	end
endmodule

// ### rtl/cscc_pkg.sv
/*
 * Shared constants for the CPU and PCI clock stop controller: register
 * offsets, field positions, reset values and latency bounds.
 * Assumes a 10 MHz sys_clk and a 32-bit APB register bus.
 */
package cscc_pkg;
	localparam int          CSCC_NUM_CPU      = 3;
	localparam int          CSCC_NUM_PCI      = 7;
	localparam int          CSCC_NUM_FRPCI    = 3;
	localparam int          CSCC_PCI_DIV      = 2;
	// register byte addresses
	localparam logic [11:0] CSCC_CTRL_OFS     = 12'h000;
	localparam logic [11:0] CSCC_CFG_OFS      = 12'h004;
	localparam logic [11:0] CSCC_STAT_OFS     = 12'h008;
	// field positions
	localparam int          CSCC_SW_HALT_BIT  = 3;
	localparam int          CSCC_FR_CFG_LSB   = 0;
	localparam int          CSCC_CPU_CFG_LSB  = 8;
	localparam int          CSCC_STAT_CPU_BIT = 0;
	localparam int          CSCC_STAT_PCI_BIT = 1;
	// reset values
	localparam logic        CSCC_SW_HALT_RST  = 1'b1;
	localparam logic [2:0]  CSCC_FR_CFG_RST   = 3'h0;
	localparam logic [2:0]  CSCC_CPU_CFG_RST  = 3'h7;
	// latency bounds in CPU and PCI output clock periods
	localparam int          CSCC_CPU_RESUME_CYC = 2;
	localparam int          CSCC_PCI_RESUME_PER = 2;
endpackage

// ### rtl/cscc_top.sv
/*
 * CPU and PCI clock stop controller: generates CPU pairs and PCI clocks,
 * stops and restarts them glitch-free from the stop pins, the PCI clocks also
 * from an APB software halt bit. Assumes stop pins synchronous to sys_clk at 10 MHz.
 */
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module cscc_top
	import cscc_pkg::*;
#(
	parameter int NCPU   = cscc_pkg::CSCC_NUM_CPU,
	parameter int NPCI   = cscc_pkg::CSCC_NUM_PCI,
	parameter int NPCIF  = cscc_pkg::CSCC_NUM_FRPCI,
	parameter int PCIDIV = cscc_pkg::CSCC_PCI_DIV
) (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// stop pins, active low
	input  wire logic              cpu_clock_stop_n,
	input  wire logic              pci_clock_stop_n,
	// cpu pairs
	output logic [NCPU-1:0]        cpu_clk_true_out,
	output logic [NCPU-1:0]        cpu_clk_comp_out,
	output logic [NCPU-1:0]        cpu_clk_comp_oe_n,
	// pci clocks
	output logic [NPCI-1:0]        pci_clk_out,
	output logic [NPCIF-1:0]       free_running_pci_out
);
	import cscc_pkg::*;

	// apb register state
	logic                  sw_r,     sw_nxt;
	logic [NPCIF-1:0]      fr_cfg_r,   fr_cfg_nxt;
	logic [NCPU-1:0]       cpu_cfg_r,  cpu_cfg_nxt;
	logic                  pready_nxt, pslverr_nxt;
	logic [31:0]           prdata_nxt;
	// cpu state
	logic                  cpu_s1_r, cpu_s2_r;
	logic                  cpu_ph_r,  cpu_ph_nxt;
	logic [1:0]            cpu_samp_r, cpu_samp_nxt;
	logic                  cpu_act_r, cpu_act_nxt;
	logic [NCPU-1:0]       cpu_stopped_r, cpu_stopped_nxt;
	logic [NCPU-1:0]       true_nxt, comp_nxt, oe_n_nxt;
	// pci state
	logic                  pci_s1_r, pci_s2_r;
	logic                  pci_tick;
	logic                  pci_ph_r,  pci_ph_nxt;
	logic                  pci_stop_r, pci_stop_nxt;
	logic                  pci_run;
	logic [NPCI-1:0]       pci_nxt;
	logic [NPCIF-1:0]      fr_nxt;
	logic                  wr_en, setup;

	cscc_div #(.DIV(PCIDIV)) u_pci_div (
		.sys_clk (sys_clk),
		.rst     (rst),
		.tick    (pci_tick)
	);

	// apb: no wait state, registered answer prepared in the setup cycle
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pready && pwrite;
	assign pci_run = pci_s2_r && sw_r;

	always_comb begin
		sw_nxt       = sw_r;
		fr_cfg_nxt   = fr_cfg_r;
		cpu_cfg_nxt  = cpu_cfg_r;
		pready_nxt   = setup;
		pslverr_nxt  = 1'b0;
		prdata_nxt   = prdata;
		if (setup) begin
			prdata_nxt = '0;
			unique case (paddr)
				CSCC_CTRL_OFS: prdata_nxt[CSCC_SW_HALT_BIT] = pci_run;
				CSCC_CFG_OFS: begin
					prdata_nxt[CSCC_FR_CFG_LSB +: NPCIF]   = fr_cfg_r;
					prdata_nxt[CSCC_CPU_CFG_LSB +: NCPU]   = cpu_cfg_r;
				end
				CSCC_STAT_OFS: begin
					prdata_nxt[CSCC_STAT_CPU_BIT] = cpu_act_r;
					prdata_nxt[CSCC_STAT_PCI_BIT] = pci_stop_r;
				end
				default: pslverr_nxt = 1'b1;
			endcase
		end
		if (wr_en) begin
			if (paddr == CSCC_CTRL_OFS) begin
				sw_nxt = pwdata[CSCC_SW_HALT_BIT];
			end
			if (paddr == CSCC_CFG_OFS) begin
				fr_cfg_nxt   = pwdata[CSCC_FR_CFG_LSB +: NPCIF];
				cpu_cfg_nxt  = pwdata[CSCC_CPU_CFG_LSB +: NCPU];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sw_r       <= CSCC_SW_HALT_RST;
			fr_cfg_r   <= NPCIF'(CSCC_FR_CFG_RST);
			cpu_cfg_r  <= NCPU'(CSCC_CPU_CFG_RST);
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= '0;
		end else begin
			sw_r       <= sw_nxt;
			fr_cfg_r   <= fr_cfg_nxt;
			cpu_cfg_r  <= cpu_cfg_nxt;
			pready     <= pready_nxt;
			pslverr    <= pslverr_nxt;
			prdata     <= prdata_nxt;
		end
	end

	// cpu: the stop decision moves only on the true rising edge, so the
	// true output is already high when it is parked there
	always_comb begin
		cpu_ph_nxt      = !cpu_ph_r;
		cpu_samp_nxt    = cpu_samp_r;
		cpu_act_nxt     = cpu_act_r;
		cpu_stopped_nxt = cpu_stopped_r;
		if (cpu_ph_nxt) begin
			cpu_samp_nxt = {cpu_samp_r[0], !cpu_s2_r};
			if (cpu_samp_nxt == 2'b11) begin
				cpu_act_nxt = 1'b1;
			end else if (!cpu_samp_nxt[0]) begin
				cpu_act_nxt = 1'b0;
			end
			cpu_stopped_nxt = cpu_act_nxt ? cpu_cfg_r : '0;
		end
		true_nxt = cpu_stopped_nxt | {NCPU{cpu_ph_nxt}};
		comp_nxt = ~cpu_stopped_nxt & {NCPU{!cpu_ph_nxt}};
		oe_n_nxt = cpu_stopped_nxt;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cpu_s1_r          <= 1'b1;
			cpu_s2_r          <= 1'b1;
			cpu_ph_r          <= 1'b0;
			cpu_samp_r        <= 2'b00;
			cpu_act_r         <= 1'b0;
			cpu_stopped_r     <= '0;
			cpu_clk_true_out  <= '0;
			cpu_clk_comp_out  <= '0;
			cpu_clk_comp_oe_n <= '0;
		end else begin
			cpu_s1_r          <= cpu_clock_stop_n;
			cpu_s2_r          <= cpu_s1_r;
			cpu_ph_r          <= cpu_ph_nxt;
			cpu_samp_r        <= cpu_samp_nxt;
			cpu_act_r         <= cpu_act_nxt;
			cpu_stopped_r     <= cpu_stopped_nxt;
			cpu_clk_true_out  <= true_nxt;
			cpu_clk_comp_out  <= comp_nxt;
			cpu_clk_comp_oe_n <= oe_n_nxt;
		end
	end

	// pci: the gate moves only on a falling edge, so parking is at low
	always_comb begin
		pci_ph_nxt   = pci_tick ? !pci_ph_r : pci_ph_r;
		pci_stop_nxt = pci_stop_r;
		if (pci_tick && !pci_ph_nxt) begin
			pci_stop_nxt = !pci_run;
		end
		pci_nxt = pci_stop_nxt ? '0 : {NPCI{pci_ph_nxt}};
		fr_nxt  = {NPCIF{pci_ph_nxt}} & ~({NPCIF{pci_stop_nxt}} & fr_cfg_r);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pci_s1_r             <= 1'b1;
			pci_s2_r             <= 1'b1;
			pci_ph_r             <= 1'b0;
			pci_stop_r           <= 1'b0;
			pci_clk_out          <= '0;
			free_running_pci_out <= '0;
		end else begin
			pci_s1_r             <= pci_clock_stop_n;
			pci_s2_r             <= pci_s1_r;
			pci_ph_r             <= pci_ph_nxt;
			pci_stop_r           <= pci_stop_nxt;
			pci_clk_out          <= pci_nxt;
			free_running_pci_out <= fr_nxt;
		end
	end

	localparam int PCI_BND = CSCC_PCI_RESUME_PER * 2 * PCIDIV + 3;

	sequence cpu_release_s;
		$rose(cpu_clock_stop_n) ##1 cpu_clock_stop_n [*5];
	endsequence
	// all pairs are high together on restart and fall one cycle later
	sequence cpu_resume_s;
		(cpu_clk_true_out == '1) ##1 (cpu_clk_true_out == '0);
	endsequence

	AST_CPU_PARK: assert property (@(posedge sys_clk) disable iff (rst)
		((cpu_stopped_r & ~(cpu_clk_true_out & cpu_clk_comp_oe_n & ~cpu_clk_comp_out)) == '0))
		else $error("stopped cpu pair not parked");
	AST_CPU_WHOLE: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(|cpu_stopped_r) |-> cpu_resume_s)
		else $error("cpu restart pulse wrong");
	AST_CPU_LAT: assert property (@(posedge sys_clk) disable iff (rst)
		cpu_release_s |-> (cpu_stopped_r == '0))
		else $error("cpu resume too late");
	AST_PCI_LOW: assert property (@(posedge sys_clk) disable iff (rst)
		pci_stop_r |-> (pci_clk_out == '0) && (cpu_ph_r != $past(cpu_ph_r)))
		else $error("pci not parked low or cpu halted");
	AST_FREE_RUN: assert property (@(posedge sys_clk) disable iff (rst)
		((free_running_pci_out ^ {NPCIF{pci_ph_r}}) & ~$past(fr_cfg_r)) == '0)
		else $error("free-running pci output stopped");
	AST_PCI_RESUME: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(pci_clock_stop_n && sw_r) |-> ##[0:PCI_BND] !pci_stop_r)
		else $error("pci resume too late");
	AST_SW_STOP: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(sw_r) |-> ##[1:PCI_BND] pci_stop_r)
		else $error("software halt ignored");
	AST_SW_READ: assert property (@(posedge sys_clk) disable iff (rst)
		(psel && penable && pready && !pwrite && paddr == CSCC_CTRL_OFS)
		|-> prdata[CSCC_SW_HALT_BIT] == $past(sw_r && pci_s2_r))
		else $error("halt readback wrong");
	AST_CPU_TWO: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(cpu_act_r) |-> !$past(cpu_s2_r) && !$past(cpu_s2_r, 3))
		else $error("cpu stop without two samples");
	AST_FREE_STOP: assert property (@(posedge sys_clk) disable iff (rst)
		pci_stop_r |-> (free_running_pci_out & $past(fr_cfg_r)) == '0)
		else $error("stoppable free-running pci output running");
	AST_GATE_LOW: assert property (@(posedge sys_clk) disable iff (rst)
		$changed(pci_stop_r) |-> !pci_ph_r)
		else $error("pci gate moved while output high");
	AST_GATE_CPU: assert property (@(posedge sys_clk) disable iff (rst)
		$changed(cpu_act_r) |-> cpu_ph_r)
		else $error("cpu gate moved off the true rising edge");
endmodule

// ### testbench/cpu_pci_clock_stop_control_tb.sv
/* Bench for the clock stop controller: APB tasks, stop scenarios, activity checks.
   Assumes the partner model drives the stop pins. */
`timescale 1ns/1ps
module cpu_pci_clock_stop_control_tb;
	import cscc_pkg::*;
	localparam logic [18:0] ALL = 19'h7FFFF;
	localparam logic [18:0] RUN = {3'h7, 3'h7, 3'h0, 7'h7F, 3'h7};
	logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic        cpu_req_n, pci_req_n, cpu_clock_stop_n, pci_clock_stop_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  cpu_clk_true_out, cpu_clk_comp_out, cpu_clk_comp_oe_n, free_running_pci_out;
	logic [6:0]  pci_clk_out;
	logic [18:0] hi, lo, v;
	int          num_errors, n_tests;

	assign v = {cpu_clk_true_out, cpu_clk_comp_out, cpu_clk_comp_oe_n, pci_clk_out,
		free_running_pci_out};

	cscc_top u_cscc_top (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .cpu_clock_stop_n(cpu_clock_stop_n),
		.pci_clock_stop_n(pci_clock_stop_n), .cpu_clk_true_out(cpu_clk_true_out),
		.cpu_clk_comp_out(cpu_clk_comp_out), .cpu_clk_comp_oe_n(cpu_clk_comp_oe_n),
		.pci_clk_out(pci_clk_out), .free_running_pci_out(free_running_pci_out));
	cscc_pm_model u_cscc_pm_model (.sys_clk(sys_clk), .rst(rst), .cpu_req_n(cpu_req_n),
		.pci_req_n(pci_req_n), .cpu_clock_stop_n(cpu_clock_stop_n),
		.pci_clock_stop_n(pci_clock_stop_n));

	task automatic final_report;
		$display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_pin(input logic [18:0] g, input logic [18:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// request held until pready is sampled high; data taken at that edge only
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1 && k < 20) begin
			k++;
			@(posedge sys_clk);
		end
		if (k == 20) num_errors++;
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pins(input logic c, input logic p);
		int k;
		k = 0;
		@(posedge sys_clk);
		cpu_req_n <= c;
		pci_req_n <= p;
		while ({cpu_clock_stop_n, pci_clock_stop_n} !== {c, p} && k < 40) begin
			k++;
			@(posedge sys_clk);
		end
		if (k == 40) num_errors++;
	endtask

	// levels seen on every output over n cycles, sampled mid-cycle
	task automatic obs(input int n);
		hi = '0;
		lo = '0;
		repeat (n) begin
			@(negedge sys_clk);
			hi = hi | v;
			lo = lo | ~v;
		end
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	initial begin
		#2000000;
		num_errors++;
		final_report;
	end

	initial begin
		rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0; cpu_req_n = 1'b1; pci_req_n = 1'b1;
		num_errors = 0;
		n_tests = 0;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		apb(1'b0, CSCC_CTRL_OFS, 32'h0); chk_reg(rd, 32'h0000_0008);
		apb(1'b0, CSCC_CFG_OFS, 32'h0); chk_reg(rd, 32'h0000_0700);
		apb(1'b0, CSCC_STAT_OFS, 32'h0); chk_reg(rd, 32'h0);
		apb(1'b0, 12'h00C, 32'h0); chk_reg({err, rd[30:0]}, 32'h8000_0000);
		obs(8); chk_pin(hi, RUN); chk_pin(lo, ALL);
		// cpu pair 0 and free-running pci 1 left running
		apb(1'b1, CSCC_CFG_OFS, 32'h0000_0605);
		apb(1'b0, CSCC_CFG_OFS, 32'h0); chk_reg(rd, 32'h0000_0605);
		pins(1'b0, 1'b1);
		repeat (6) @(posedge sys_clk);
		obs(6); chk_pin(hi, {3'h7, 3'h1, 3'h6, 7'h7F, 3'h7});
		chk_pin(lo, {3'h1, 3'h7, 3'h1, 7'h7F, 3'h7});
		apb(1'b0, CSCC_STAT_OFS, 32'h0); chk_reg(rd, 32'h0000_0001);
		pins(1'b1, 1'b1);
		repeat (6) @(posedge sys_clk);
		obs(4); chk_pin(hi, RUN); chk_pin(lo, ALL);
		// stop by pin, then by software bit
		for (int s = 0; s < 2; s++) begin
			if (s == 0) pins(1'b1, 1'b0);
			else apb(1'b1, CSCC_CTRL_OFS, 32'h0);
			repeat (10) @(posedge sys_clk);
			obs(8); chk_pin(hi, {3'h7, 3'h7, 3'h0, 7'h00, 3'h2});
			chk_pin(lo, ALL);
			apb(1'b0, CSCC_CTRL_OFS, 32'h0); chk_reg(rd, 32'h0);
			apb(1'b0, CSCC_STAT_OFS, 32'h0); chk_reg(rd, 32'h0000_0002);
			if (s == 0) pins(1'b1, 1'b1);
			else apb(1'b1, CSCC_CTRL_OFS, 32'h0000_0008);
			repeat (10) @(posedge sys_clk);
			obs(5); chk_pin(hi, RUN); chk_pin(lo, ALL);
		end
		apb(1'b0, CSCC_CTRL_OFS, 32'h0); chk_reg(rd, 32'h0000_0008);
		final_report;
	end
endmodule

// ### testbench/cscc_pm_model.sv
/* Power-management partner: drives the two active-low stop pins.
   Assumes the bench requests levels; each pin level stands at least HOLD+1 cycles. */
`timescale 1ns/1ps
module cscc_pm_model #(
	parameter int HOLD = 12
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// requested levels
	input  wire logic cpu_req_n,
	input  wire logic pci_req_n,
	// stop pins, pulled up while reset
	output logic      cpu_clock_stop_n,
	output logic      pci_clock_stop_n
);
	int hold_r;
	// a slow controller: a level moves only once the last one stood long enough
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cpu_clock_stop_n <= 1'b1;
			pci_clock_stop_n <= 1'b1;
			hold_r           <= 0;
		end else if (hold_r < HOLD) begin
			hold_r <= hold_r + 1;
		end else if ({cpu_req_n, pci_req_n} != {cpu_clock_stop_n, pci_clock_stop_n}) begin
			cpu_clock_stop_n <= cpu_req_n;
			pci_clock_stop_n <= pci_req_n;
			hold_r           <= 0;
		end
	end
endmodule
